// >>> wim_top.sv
// register front end, cause mapping and interrupt output of the mask bank
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RULE1] primary bits 0-5: receive good, desc done, error, no frame, end, overrun
// [RULE2] primary bits 6-11: transmit good, desc done, error, no frame, end, underrun
// [RULE3] bits 12-16: stats counter, software, phy error, key miss, beacon alert
// [RULE4] bits 17-20: beacon strength, missed, tx mitigation, not ready; 21 reserved
// [RULE5] bit 22 contention poll, bit 23 beacon summary, bit 24 rx mitigation
// [RULE6] first secondary mask read/write at 0x100000a4, resets to zero
// [RULE7] first secondary bits 16+n: descriptor done of queue n; 31:26 reserved
// [RULE8] first secondary bits n: transmit good of queue n; 15:10 reserved
// [RULE9] warm reset clears secondary masks to zero like cold reset
// [RULE10] second secondary mask read/write at 0x100000a8, resets to zero
// [RULE11] second secondary bits 16+n: end of list of queue n; 31:26 reserved
// [RULE12] second secondary bits n: transmit error of queue n; 15:10 reserved
// [RULE13] third secondary mask at 0x100000ac, zero after cold and warm reset
// [RULE14] third secondary bits n: underrun of queue n; bits 21:10 reserved
// [RULE15] primary bits 25-27: queue rate overflow, rate underrun, queue trigger
// [RULE16] cause reaches the interrupt only while its mask bit is one
module wim_top (
    input  wire logic        MCLK_I,
    input  wire logic        RST_B_I,
    input  wire logic        WARM_RST_B_I,
    input  wire logic [31:0] ADDR_I,
    input  wire logic [31:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [31:0] RDATA_O,
    output logic             IRQ_O,
    input  wire logic        RX_FRAME_GOOD_I,
    input  wire logic        RX_DESCRIPTOR_DONE_I,
    input  wire logic        RX_FRAME_ERROR_I,
    input  wire logic        RX_NO_FRAME_I,
    input  wire logic        RX_LIST_END_I,
    input  wire logic        RX_OVERRUN_I,
    input  wire logic        TX_FRAME_GOOD_I,
    input  wire logic        TX_DESCRIPTOR_DONE_I,
    input  wire logic        TX_FRAME_ERROR_I,
    input  wire logic        TX_NO_FRAME_I,
    input  wire logic        TX_LIST_END_I,
    input  wire logic        TX_UNDERRUN_I,
    input  wire logic        STATS_COUNTER_EVENT_I,
    input  wire logic        SOFTWARE_RAISED_EVENT_I,
    input  wire logic        RX_PHY_ERROR_I,
    input  wire logic        KEY_CACHE_MISS_I,
    input  wire logic        SOFTWARE_BEACON_ALERT_I,
    input  wire logic        BEACON_STRENGTH_THRESHOLD_I,
    input  wire logic        BEACON_MISSED_I,
    input  wire logic        TX_MITIGATION_EVENT_I,
    input  wire logic        BEACON_NOT_READY_I,
    input  wire logic        CONTENTION_FREE_POLL_I,
    input  wire logic        BEACON_MISC_SUMMARY_I,
    input  wire logic        RX_MITIGATION_EVENT_I,
    input  wire logic        QUEUE_RATE_OVERFLOW_I,
    input  wire logic        QUEUE_RATE_UNDERRUN_I,
    input  wire logic        QUEUE_TRIGGER_EVENT_I,
    input  wire logic [9:0]  Q_DESCRIPTOR_DONE_I,
    input  wire logic [9:0]  Q_TX_FRAME_GOOD_I,
    input  wire logic [9:0]  Q_LIST_END_I,
    input  wire logic [9:0]  Q_TX_FRAME_ERROR_I,
    input  wire logic [9:0]  Q_TX_UNDERRUN_I,
    input  wire logic [9:0]  BEACON_TIMING_EVENT_I
);

    wim_pkg::wim_top_state_type       st_q;
    wim_pkg::wim_top_state_type       st_d;
    logic [31:0]                      pri_cause;
    logic [31:0]                      qds_cause;
    logic [31:0]                      qee_cause;
    logic [31:0]                      qub_cause;
    logic [wim_pkg::NUM_WORDS-1:0][31:0] pend;
    logic [wim_pkg::NUM_WORDS-1:0]    word_hit;
    logic [wim_pkg::NUM_WORDS-1:0]    mask_sel;
    logic [wim_pkg::NUM_WORDS-1:0]    stat_sel;

    wim_bank_if bank_bus ();

    wim_mask_bank u_bank (
        .clk_i        (MCLK_I),
        .rst_b_i      (RST_B_I),
        .warm_rst_b_i (WARM_RST_B_I),
        .bus          (bank_bus.bank)
    );

    // primary causes placed at their enable positions
    always_comb begin
        pri_cause = 32'h00000000;
        pri_cause[wim_pkg::POS_RX_FRAME_GOOD]      = RX_FRAME_GOOD_I; // [RULE1]
        pri_cause[wim_pkg::POS_RX_DESCRIPTOR_DONE] =
            RX_DESCRIPTOR_DONE_I; // [RULE1]
        pri_cause[wim_pkg::POS_RX_FRAME_ERROR]     = RX_FRAME_ERROR_I; // [RULE1]
        pri_cause[wim_pkg::POS_RX_NO_FRAME]        = RX_NO_FRAME_I; // [RULE1]
        pri_cause[wim_pkg::POS_RX_LIST_END]        = RX_LIST_END_I; // [RULE1]
        pri_cause[wim_pkg::POS_RX_OVERRUN]         = RX_OVERRUN_I; // [RULE1]
        pri_cause[wim_pkg::POS_TX_FRAME_GOOD]      = TX_FRAME_GOOD_I; // [RULE2]
        pri_cause[wim_pkg::POS_TX_DESCRIPTOR_DONE] =
            TX_DESCRIPTOR_DONE_I; // [RULE2]
        pri_cause[wim_pkg::POS_TX_FRAME_ERROR]     = TX_FRAME_ERROR_I; // [RULE2]
        pri_cause[wim_pkg::POS_TX_NO_FRAME]        = TX_NO_FRAME_I; // [RULE2]
        pri_cause[wim_pkg::POS_TX_LIST_END]        = TX_LIST_END_I; // [RULE2]
        pri_cause[wim_pkg::POS_TX_UNDERRUN]        = TX_UNDERRUN_I; // [RULE2]
        pri_cause[wim_pkg::POS_STATS_COUNTER]      =
            STATS_COUNTER_EVENT_I; // [RULE3]
        // software may raise its own cause through the trigger register
        pri_cause[wim_pkg::POS_SOFTWARE_RAISED]    =
            SOFTWARE_RAISED_EVENT_I | st_q.sw_trig; // [RULE3]
        pri_cause[wim_pkg::POS_RX_PHY_ERROR]       = RX_PHY_ERROR_I; // [RULE3]
        pri_cause[wim_pkg::POS_KEY_CACHE_MISS]     = KEY_CACHE_MISS_I; // [RULE3]
        pri_cause[wim_pkg::POS_SW_BEACON_ALERT]    =
            SOFTWARE_BEACON_ALERT_I; // [RULE3]
        pri_cause[wim_pkg::POS_BEACON_STRENGTH]    =
            BEACON_STRENGTH_THRESHOLD_I; // [RULE4]
        pri_cause[wim_pkg::POS_BEACON_MISSED]      = BEACON_MISSED_I; // [RULE4]
        pri_cause[wim_pkg::POS_TX_MITIGATION]      =
            TX_MITIGATION_EVENT_I; // [RULE4]
        pri_cause[wim_pkg::POS_BEACON_NOT_READY]   =
            BEACON_NOT_READY_I; // [RULE4]
        pri_cause[wim_pkg::POS_PRI_RESERVED]       = 1'b0; // [RULE4]
        pri_cause[wim_pkg::POS_CONTENTION_POLL]    =
            CONTENTION_FREE_POLL_I; // [RULE5]
        pri_cause[wim_pkg::POS_BEACON_MISC]        =
            BEACON_MISC_SUMMARY_I; // [RULE5]
        pri_cause[wim_pkg::POS_RX_MITIGATION]      =
            RX_MITIGATION_EVENT_I; // [RULE5]
        pri_cause[wim_pkg::POS_QUEUE_RATE_OVF]     =
            QUEUE_RATE_OVERFLOW_I; // [RULE15]
        pri_cause[wim_pkg::POS_QUEUE_RATE_URN]     =
            QUEUE_RATE_UNDERRUN_I; // [RULE15]
        pri_cause[wim_pkg::POS_QUEUE_TRIGGER]      =
            QUEUE_TRIGGER_EVENT_I; // [RULE15]
    end

    // per-queue causes: queue n at bit n, and at bit 16+n in the first two secondary words
    always_comb begin
        qds_cause = 32'h00000000;
        qee_cause = 32'h00000000;
        qub_cause = 32'h00000000;
        qds_cause[wim_pkg::QUEUE_HI_POS +: wim_pkg::NUM_QUEUES] =
            Q_DESCRIPTOR_DONE_I; // [RULE7]
        qds_cause[wim_pkg::QUEUE_LO_POS +: wim_pkg::NUM_QUEUES] =
            Q_TX_FRAME_GOOD_I; // [RULE8]
        qee_cause[wim_pkg::QUEUE_HI_POS +: wim_pkg::NUM_QUEUES] =
            Q_LIST_END_I; // [RULE11]
        qee_cause[wim_pkg::QUEUE_LO_POS +: wim_pkg::NUM_QUEUES] =
            Q_TX_FRAME_ERROR_I; // [RULE12]
        qub_cause[wim_pkg::QUEUE_LO_POS +: wim_pkg::NUM_QUEUES] =
            Q_TX_UNDERRUN_I; // [RULE14]
        qub_cause[wim_pkg::BEACON_LO_POS +: wim_pkg::BEACON_WIDTH] =
            BEACON_TIMING_EVENT_I;
    end

    assign bank_bus.cause[wim_pkg::WORD_PRI] = pri_cause;
    assign bank_bus.cause[wim_pkg::WORD_QDS] = qds_cause;
    assign bank_bus.cause[wim_pkg::WORD_QEE] = qee_cause;
    assign bank_bus.cause[wim_pkg::WORD_QUB] = qub_cause;

    // write decode: masks store, status words clear where a one is written
    always_comb begin
        mask_sel = '0;
        stat_sel = '0;
        case (ADDR_I)
            wim_pkg::PRI_MASK_ADDR: begin
                mask_sel[wim_pkg::WORD_PRI] = 1'b1;
            end
            wim_pkg::QDS_MASK_ADDR: begin
                mask_sel[wim_pkg::WORD_QDS] = 1'b1; // [RULE6]
            end
            wim_pkg::QEE_MASK_ADDR: begin
                mask_sel[wim_pkg::WORD_QEE] = 1'b1; // [RULE10]
            end
            wim_pkg::QUB_MASK_ADDR: begin
                mask_sel[wim_pkg::WORD_QUB] = 1'b1; // [RULE13]
            end
            wim_pkg::PRI_STAT_ADDR: begin
                stat_sel[wim_pkg::WORD_PRI] = 1'b1;
            end
            wim_pkg::QDS_STAT_ADDR: begin
                stat_sel[wim_pkg::WORD_QDS] = 1'b1;
            end
            wim_pkg::QEE_STAT_ADDR: begin
                stat_sel[wim_pkg::WORD_QEE] = 1'b1;
            end
            wim_pkg::QUB_STAT_ADDR: begin
                stat_sel[wim_pkg::WORD_QUB] = 1'b1;
            end
            default: begin
                mask_sel = '0;
                stat_sel = '0;
            end
        endcase
    end

    assign bank_bus.mask_wr  = WR_I ? mask_sel : '0;
    assign bank_bus.stat_clr = WR_I ? stat_sel : '0;
    assign bank_bus.wdata    = WDATA_I;

    // pending view per word: status passed only where enabled
    for (genvar w = 0; w < wim_pkg::NUM_WORDS; w++) begin : g_pend
        assign pend[w] = bank_bus.stat_q[w] & bank_bus.mask_q[w]; // [RULE16]
        assign word_hit[w] = |pend[w];
    end

    always_comb begin
        st_d = st_q;
        st_d.rdata = 32'h00000000;
        st_d.irq = |word_hit; // [RULE16]
        st_d.sw_trig = WR_I && (ADDR_I == wim_pkg::SW_TRIG_ADDR)
                       && WDATA_I[0];
        if (RD_I) begin
            case (ADDR_I)
                wim_pkg::PRI_MASK_ADDR: begin
                    st_d.rdata = bank_bus.mask_q[wim_pkg::WORD_PRI];
                end
                wim_pkg::QDS_MASK_ADDR: begin
                    st_d.rdata = bank_bus.mask_q[wim_pkg::WORD_QDS]; // [RULE6]
                end
                wim_pkg::QEE_MASK_ADDR: begin
                    st_d.rdata = bank_bus.mask_q[wim_pkg::WORD_QEE]; // [RULE10]
                end
                wim_pkg::QUB_MASK_ADDR: begin
                    st_d.rdata = bank_bus.mask_q[wim_pkg::WORD_QUB]; // [RULE13]
                end
                wim_pkg::PRI_STAT_ADDR: begin
                    st_d.rdata = bank_bus.stat_q[wim_pkg::WORD_PRI];
                end
                wim_pkg::QDS_STAT_ADDR: begin
                    st_d.rdata = bank_bus.stat_q[wim_pkg::WORD_QDS];
                end
                wim_pkg::QEE_STAT_ADDR: begin
                    st_d.rdata = bank_bus.stat_q[wim_pkg::WORD_QEE];
                end
                wim_pkg::QUB_STAT_ADDR: begin
                    st_d.rdata = bank_bus.stat_q[wim_pkg::WORD_QUB];
                end
                wim_pkg::PRI_PEND_ADDR: begin
                    st_d.rdata = pend[wim_pkg::WORD_PRI];
                end
                wim_pkg::QDS_PEND_ADDR: begin
                    st_d.rdata = pend[wim_pkg::WORD_QDS];
                end
                wim_pkg::QEE_PEND_ADDR: begin
                    st_d.rdata = pend[wim_pkg::WORD_QEE];
                end
                wim_pkg::QUB_PEND_ADDR: begin
                    st_d.rdata = pend[wim_pkg::WORD_QUB];
                end
                default: begin
                    st_d.rdata = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I || !WARM_RST_B_I) begin
            st_q <= wim_pkg::TOP_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign RDATA_O = st_q.rdata;
    assign IRQ_O   = st_q.irq;

endmodule
`default_nettype wire

// >>> wim_pkg.sv
// constants and types shared by the wlan interrupt mask bank
package wim_pkg;

    localparam int NUM_WORDS  = 4;
    localparam int NUM_QUEUES = 10;

    // register byte addresses
    localparam logic [31:0] PRI_MASK_ADDR  = 32'h100000a0;
    localparam logic [31:0] QDS_MASK_ADDR  = 32'h100000a4;
    localparam logic [31:0] QEE_MASK_ADDR  = 32'h100000a8;
    localparam logic [31:0] QUB_MASK_ADDR  = 32'h100000ac;
    localparam logic [31:0] PRI_STAT_ADDR  = 32'h10000100;
    localparam logic [31:0] QDS_STAT_ADDR  = 32'h10000104;
    localparam logic [31:0] QEE_STAT_ADDR  = 32'h10000108;
    localparam logic [31:0] QUB_STAT_ADDR  = 32'h1000010c;
    localparam logic [31:0] PRI_PEND_ADDR  = 32'h10000110;
    localparam logic [31:0] QDS_PEND_ADDR  = 32'h10000114;
    localparam logic [31:0] QEE_PEND_ADDR  = 32'h10000118;
    localparam logic [31:0] QUB_PEND_ADDR  = 32'h1000011c;
    localparam logic [31:0] SW_TRIG_ADDR   = 32'h10000120;

    // word index inside the bank
    localparam int WORD_PRI = 0;
    localparam int WORD_QDS = 1;
    localparam int WORD_QEE = 2;
    localparam int WORD_QUB = 3;

    // values after cold or warm reset
    localparam logic [31:0] MASK_RESET = 32'h00000000;
    localparam logic [31:0] STAT_RESET = 32'h00000000;

    // primary word bit positions
    localparam int POS_RX_FRAME_GOOD      = 0;
    localparam int POS_RX_DESCRIPTOR_DONE = 1;
    localparam int POS_RX_FRAME_ERROR     = 2;
    localparam int POS_RX_NO_FRAME        = 3;
    localparam int POS_RX_LIST_END        = 4;
    localparam int POS_RX_OVERRUN         = 5;
    localparam int POS_TX_FRAME_GOOD      = 6;
    localparam int POS_TX_DESCRIPTOR_DONE = 7;
    localparam int POS_TX_FRAME_ERROR     = 8;
    localparam int POS_TX_NO_FRAME        = 9;
    localparam int POS_TX_LIST_END        = 10;
    localparam int POS_TX_UNDERRUN        = 11;
    localparam int POS_STATS_COUNTER      = 12;
    localparam int POS_SOFTWARE_RAISED    = 13;
    localparam int POS_RX_PHY_ERROR       = 14;
    localparam int POS_KEY_CACHE_MISS     = 15;
    localparam int POS_SW_BEACON_ALERT    = 16;
    localparam int POS_BEACON_STRENGTH    = 17;
    localparam int POS_BEACON_MISSED      = 18;
    localparam int POS_TX_MITIGATION      = 19;
    localparam int POS_BEACON_NOT_READY   = 20;
    localparam int POS_PRI_RESERVED       = 21;
    localparam int POS_CONTENTION_POLL    = 22;
    localparam int POS_BEACON_MISC        = 23;
    localparam int POS_RX_MITIGATION      = 24;
    localparam int POS_QUEUE_RATE_OVF     = 25;
    localparam int POS_QUEUE_RATE_URN     = 26;
    localparam int POS_QUEUE_TRIGGER      = 27;

    // per-queue fields of the secondary words
    localparam int QUEUE_LO_POS  = 0;
    localparam int QUEUE_HI_POS  = 16;
    localparam int BEACON_LO_POS = 22;
    localparam int BEACON_WIDTH  = 10;

    // implemented bits of each word; all others read as zero
    localparam logic [31:0] PRI_KEEP = 32'h0fdfffff;
    localparam logic [31:0] QDS_KEEP = 32'h03ff03ff;
    localparam logic [31:0] QEE_KEEP = 32'h03ff03ff;
    localparam logic [31:0] QUB_KEEP = 32'hffc003ff;
    localparam logic [NUM_WORDS-1:0][31:0] WORD_KEEP =
        {QUB_KEEP, QEE_KEEP, QDS_KEEP, PRI_KEEP};

    typedef struct packed {
        logic [NUM_WORDS-1:0][31:0] mask;
        logic [NUM_WORDS-1:0][31:0] stat;
    } wim_bank_state_type;

    typedef struct packed {
        logic [31:0] rdata;
        logic        irq;
        logic        sw_trig;
    } wim_top_state_type;

    localparam wim_bank_state_type BANK_RESET =
        {{NUM_WORDS{MASK_RESET}}, {NUM_WORDS{STAT_RESET}}};
    localparam wim_top_state_type TOP_RESET = '0;

endpackage

// >>> wim_bank_if.sv
// carrier between the register front end and the mask/status bank
`timescale 1ns/1ps
`default_nettype none
interface wim_bank_if;
    logic [wim_pkg::NUM_WORDS-1:0]       mask_wr;
    logic [wim_pkg::NUM_WORDS-1:0]       stat_clr;
    logic [31:0]                         wdata;
    logic [wim_pkg::NUM_WORDS-1:0][31:0] cause;
    logic [wim_pkg::NUM_WORDS-1:0][31:0] mask_q;
    logic [wim_pkg::NUM_WORDS-1:0][31:0] stat_q;

    modport ctrl (
        output mask_wr,
        output stat_clr,
        output wdata,
        output cause,
        input  mask_q,
        input  stat_q
    );

    modport bank (
        input  mask_wr,
        input  stat_clr,
        input  wdata,
        input  cause,
        output mask_q,
        output stat_q
    );
endinterface
`default_nettype wire

// >>> wim_mask_bank.sv
// mask and sticky status storage for the four interrupt words
`timescale 1ns/1ps
`default_nettype none
module wim_mask_bank (
    input  wire logic   clk_i,
    input  wire logic   rst_b_i,
    input  wire logic   warm_rst_b_i,
    wim_bank_if.bank    bus
);

    wim_pkg::wim_bank_state_type st_q;
    wim_pkg::wim_bank_state_type st_d;

    always_comb begin
        st_d = st_q;
        for (int w = 0; w < wim_pkg::NUM_WORDS; w++) begin
            if (bus.mask_wr[w]) begin
                st_d.mask[w] = bus.wdata & wim_pkg::WORD_KEEP[w];
            end
            // a cause in the clearing cycle survives; mask never touches it
            st_d.stat[w] = ((st_q.stat[w]
                           & ~(bus.stat_clr[w] ? bus.wdata : 32'h00000000))
                           | bus.cause[w]) & wim_pkg::WORD_KEEP[w]; // [RULE16]
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i || !warm_rst_b_i) begin
            st_q <= wim_pkg::BANK_RESET; // [RULE9] [RULE13]
        end else begin
            st_q <= st_d;
        end
    end

    assign bus.mask_q = st_q.mask;
    assign bus.stat_q = st_q.stat;

endmodule
`default_nettype wire

// >>> wim_top_checker.sv
// port-level assertions for the wlan interrupt mask bank
`timescale 1ns/1ps
`default_nettype none
module wim_top_checker (
    input wire logic        MCLK_I,
    input wire logic        RST_B_I,
    input wire logic        WARM_RST_B_I,
    input wire logic [31:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic        WR_I,
    input wire logic        RD_I,
    input wire logic [31:0] RDATA_O,
    input wire logic        IRQ_O
);
    logic mask_seen_q;

    // any mask write since the last reset; no enable means no interrupt
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I || !WARM_RST_B_I) begin
            mask_seen_q <= 1'b0;
        end else if (WR_I && (ADDR_I inside {wim_pkg::PRI_MASK_ADDR,
                wim_pkg::QDS_MASK_ADDR, wim_pkg::QEE_MASK_ADDR,
                wim_pkg::QUB_MASK_ADDR})) begin
            mask_seen_q <= 1'b1;
        end
    end

    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RST_B_I || !WARM_RST_B_I);

    property p_back(logic [31:0] a, logic [31:0] k);
        WR_I && ADDR_I == a ##1 RD_I && ADDR_I == a
            |=> RDATA_O == ($past(WDATA_I, 2) & k);
    endproperty

    property p_resv(logic [31:0] a, logic [31:0] k);
        RD_I && ADDR_I == a |=> (RDATA_O & k) == 32'h00000000;
    endproperty

    a_qds_readback: assert property (
        p_back(wim_pkg::QDS_MASK_ADDR, 32'h03ff03ff))
        else $error("first queue mask readback wrong");
    a_qee_readback: assert property (
        p_back(wim_pkg::QEE_MASK_ADDR, 32'h03ff03ff))
        else $error("second queue mask readback wrong");
    a_qub_readback: assert property (
        p_back(wim_pkg::QUB_MASK_ADDR, 32'hffc003ff))
        else $error("third queue mask readback wrong");
    a_qds_reserved_zero: assert property (
        p_resv(wim_pkg::QDS_MASK_ADDR, 32'hfc00fc00))
        else $error("first queue mask reserved bits set");
    a_qee_reserved_zero: assert property (
        p_resv(wim_pkg::QEE_MASK_ADDR, 32'hfc00fc00))
        else $error("second queue mask reserved bits set");
    a_qub_reserved_zero: assert property (
        p_resv(wim_pkg::QUB_MASK_ADDR, 32'h003ffc00))
        else $error("third queue mask reserved bits set");
    a_pri_reserved_zero: assert property (
        p_resv(wim_pkg::PRI_MASK_ADDR, 32'hf0200000))
        else $error("primary mask reserved bit set");
    a_warm_clears_mask: assert property (
        disable iff (!RST_B_I)
        $rose(WARM_RST_B_I) && RD_I && ADDR_I == wim_pkg::QDS_MASK_ADDR
            |=> RDATA_O == 32'h00000000)
        else $error("mask not cleared by warm reset");
    a_irq_needs_mask: assert property (
        IRQ_O |-> $past(mask_seen_q))
        else $error("interrupt with every enable clear");
    a_rdata_idle_zero: assert property (
        !RD_I |=> RDATA_O == 32'h00000000)
        else $error("read data stands outside its read cycle");

    c_readback: cover property (WR_I ##1 RD_I);
    c_irq_rise: cover property ($rose(IRQ_O));
    c_warm: cover property (disable iff (!RST_B_I) $rose(WARM_RST_B_I));
endmodule

bind wim_top wim_top_checker i_wim_top_checker (
    .MCLK_I       (MCLK_I),
    .RST_B_I      (RST_B_I),
    .WARM_RST_B_I (WARM_RST_B_I),
    .ADDR_I       (ADDR_I),
    .WDATA_I      (WDATA_I),
    .WR_I         (WR_I),
    .RD_I         (RD_I),
    .RDATA_O      (RDATA_O),
    .IRQ_O        (IRQ_O)
);
`default_nettype wire

// >>> wim_top_bench.sv
// self-checking bench for the wlan interrupt mask bank
`timescale 1ns/1ps
`default_nettype none
module wim_top_bench;
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [31:0] exp;
    } wim_row_type;

    localparam logic [3:0][31:0] KEEP = {32'hffc003ff, 32'h03ff03ff,
        32'h03ff03ff, 32'h0fdfffff};
    localparam logic [3:0][31:0] MASK_A = {wim_pkg::QUB_MASK_ADDR,
        wim_pkg::QEE_MASK_ADDR, wim_pkg::QDS_MASK_ADDR,
        wim_pkg::PRI_MASK_ADDR};
    localparam logic [3:0][31:0] STAT_A = {wim_pkg::QUB_STAT_ADDR,
        wim_pkg::QEE_STAT_ADDR, wim_pkg::QDS_STAT_ADDR,
        wim_pkg::PRI_STAT_ADDR};
    localparam wim_row_type ROWS [8] = '{
        '{wim_pkg::PRI_MASK_ADDR, 32'hffffffff, 32'h0fdfffff},
        '{wim_pkg::QDS_MASK_ADDR, 32'hffffffff, 32'h03ff03ff},
        '{wim_pkg::QEE_MASK_ADDR, 32'hffffffff, 32'h03ff03ff},
        '{wim_pkg::QUB_MASK_ADDR, 32'hffffffff, 32'hffc003ff},
        '{wim_pkg::QDS_MASK_ADDR, 32'ha5a5a5a5, 32'h01a501a5},
        '{wim_pkg::QEE_MASK_ADDR, 32'h5a5a5a5a, 32'h025a025a},
        '{wim_pkg::QUB_MASK_ADDR, 32'h12345678, 32'h12000278},
        '{32'h100000b0, 32'hffffffff, 32'h00000000}
    };

    logic             MCLK_I       = 1'b0;
    logic             RST_B_I      = 1'b0;
    logic             WARM_RST_B_I = 1'b1;
    logic [31:0]      ADDR_I       = '0;
    logic [31:0]      WDATA_I      = '0;
    logic             WR_I         = 1'b0;
    logic             RD_I         = 1'b0;
    logic [31:0]      RDATA_O;
    logic             IRQ_O;
    logic [3:0][31:0] cause        = '0;
    logic [31:0]      q;
    int               failures     = 0;
    int               total_checks = 0;

    wim_top i_wim_top (
        .MCLK_I(MCLK_I), .RST_B_I(RST_B_I), .WARM_RST_B_I(WARM_RST_B_I),
        .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
        .RDATA_O(RDATA_O), .IRQ_O(IRQ_O),
        .RX_FRAME_GOOD_I(cause[0][0]), .RX_DESCRIPTOR_DONE_I(cause[0][1]),
        .RX_FRAME_ERROR_I(cause[0][2]), .RX_NO_FRAME_I(cause[0][3]),
        .RX_LIST_END_I(cause[0][4]), .RX_OVERRUN_I(cause[0][5]),
        .TX_FRAME_GOOD_I(cause[0][6]), .TX_DESCRIPTOR_DONE_I(cause[0][7]),
        .TX_FRAME_ERROR_I(cause[0][8]), .TX_NO_FRAME_I(cause[0][9]),
        .TX_LIST_END_I(cause[0][10]), .TX_UNDERRUN_I(cause[0][11]),
        .STATS_COUNTER_EVENT_I(cause[0][12]),
        .SOFTWARE_RAISED_EVENT_I(cause[0][13]),
        .RX_PHY_ERROR_I(cause[0][14]), .KEY_CACHE_MISS_I(cause[0][15]),
        .SOFTWARE_BEACON_ALERT_I(cause[0][16]),
        .BEACON_STRENGTH_THRESHOLD_I(cause[0][17]),
        .BEACON_MISSED_I(cause[0][18]),
        .TX_MITIGATION_EVENT_I(cause[0][19]),
        .BEACON_NOT_READY_I(cause[0][20]),
        .CONTENTION_FREE_POLL_I(cause[0][22]),
        .BEACON_MISC_SUMMARY_I(cause[0][23]),
        .RX_MITIGATION_EVENT_I(cause[0][24]),
        .QUEUE_RATE_OVERFLOW_I(cause[0][25]),
        .QUEUE_RATE_UNDERRUN_I(cause[0][26]),
        .QUEUE_TRIGGER_EVENT_I(cause[0][27]),
        .Q_DESCRIPTOR_DONE_I(cause[1][25:16]),
        .Q_TX_FRAME_GOOD_I(cause[1][9:0]),
        .Q_LIST_END_I(cause[2][25:16]), .Q_TX_FRAME_ERROR_I(cause[2][9:0]),
        .Q_TX_UNDERRUN_I(cause[3][9:0]),
        .BEACON_TIMING_EVENT_I(cause[3][31:22])
    );

    always #25 MCLK_I = ~MCLK_I;

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge MCLK_I);
        WR_I <= 1'b1;
        ADDR_I <= a;
        WDATA_I <= d;
        @(posedge MCLK_I);
        WR_I <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a);
        @(posedge MCLK_I);
        RD_I <= 1'b1;
        ADDR_I <= a;
        @(posedge MCLK_I);
        RD_I <= 1'b0;
        #1;
        q = RDATA_O;
    endtask

    // write and read back with no idle cycle between them
    task automatic wr_rd(input logic [31:0] a, input logic [31:0] d);
        wr(a, d);
        RD_I <= 1'b1;
        @(posedge MCLK_I);
        RD_I <= 1'b0;
        #1;
        q = RDATA_O;
    endtask

    // one cause pulse: recorded while blocked, then raises the line once enabled
    task automatic probe(input int w, input int b);
        logic [31:0] v;
        v = 32'h1 << b;
        @(posedge MCLK_I);
        cause[w] <= v;
        @(posedge MCLK_I);
        cause[w] <= '0;
        repeat (3) @(posedge MCLK_I);
        #1;
        chk("irq while blocked", {31'h0, IRQ_O}, 32'h0);
        rd(STAT_A[w]);
        chk("status recorded", q, v);
        wr(MASK_A[w], v);
        repeat (2) @(posedge MCLK_I);
        #1;
        chk("irq enabled", {31'h0, IRQ_O}, 32'h1);
        wr(STAT_A[w], v);
        wr(MASK_A[w], 32'h0);
        repeat (2) @(posedge MCLK_I);
        #1;
        chk("irq cleared", {31'h0, IRQ_O}, 32'h0);
    endtask

    task automatic report_and_stop;
        if (failures == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge MCLK_I);
        RST_B_I <= 1'b1;
        for (int w = 0; w < 4; w++) begin
            rd(MASK_A[w]);
            chk("mask cold reset", q, 32'h0);
        end
        foreach (ROWS[i]) begin
            wr_rd(ROWS[i].addr, ROWS[i].wdata);
            chk("mask readback", q, ROWS[i].exp);
        end
        for (int w = 0; w < 4; w++) begin
            wr(MASK_A[w], 32'hffffffff);
        end
        @(posedge MCLK_I);
        WARM_RST_B_I <= 1'b0;
        repeat (2) @(posedge MCLK_I);
        WARM_RST_B_I <= 1'b1;
        RD_I <= 1'b1;
        ADDR_I <= wim_pkg::QDS_MASK_ADDR;
        @(posedge MCLK_I);
        RD_I <= 1'b0;
        #1;
        chk("read at warm release", RDATA_O, 32'h0);
        for (int w = 0; w < 4; w++) begin
            rd(MASK_A[w]);
            chk("mask warm reset", q, 32'h0);
        end
        for (int w = 0; w < 4; w++) begin
            for (int b = 0; b < 32; b++) begin
                if (KEEP[w][b]) begin
                    probe(w, b);
                end
            end
        end
        // software trigger sets its own cause; pending words ignore writes
        wr(wim_pkg::SW_TRIG_ADDR, 32'h00000001);
        rd(wim_pkg::PRI_STAT_ADDR);
        chk("software trigger", q, 32'h00002000);
        wr(wim_pkg::PRI_MASK_ADDR, 32'h00002000);
        wr(wim_pkg::PRI_PEND_ADDR, 32'hffffffff);
        rd(wim_pkg::PRI_PEND_ADDR);
        chk("pending view", q, 32'h00002000);
        @(posedge MCLK_I);
        #1;
        chk("read data one cycle", RDATA_O, 32'h0);
        chk("irq from trigger", {31'h0, IRQ_O}, 32'h1);
        rd(wim_pkg::SW_TRIG_ADDR);
        chk("trigger reads zero", q, 32'h0);
        report_and_stop;
    end

    initial begin
        repeat (5000) @(posedge MCLK_I);
        failures++;
        report_and_stop;
    end
endmodule
`default_nettype wire
